//--- bench/host_port_strobe_handshake_bench.sv
// bench joining host end and device end through the pin interface
// assumes a fetch model and memory sink here; drives inputs on falling edges
`timescale 1ns/1ps
module host_port_strobe_handshake_bench;
  logic core_clk, rst_b, narrow_bus_mode, fetch_req, wr_valid, wr_ready;
  logic fetch_ack = 1'b0;
  logic cmd_valid, cmd_ready, cmd_read, cmd_half, rsp_valid;
  hps_pkg::hps_ctl_t cmd_ctl;
  hps_pkg::hps_word_t fetch_data, wr_data, rsp_data, cmd_wdata, exp_w;
  hps_pkg::hps_word_t drained[$];
  int n_fail, samples_checked, fdly, fcnt, n_fetch, i;
  hps_if pins ();
  hps_host i_hps_host (.core_clk(core_clk), .rst_b(rst_b), .pins(pins.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_half(cmd_half),
    .cmd_ctl(cmd_ctl), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  hps_device i_hps_device (.core_clk(core_clk), .rst_b(rst_b), .pins(pins.dev),
    .narrow_bus_mode(narrow_bus_mode), .fetch_req(fetch_req), .fetch_ack(fetch_ack),
    .fetch_data(fetch_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data));
  hps_assertions i_hps_assertions (.core_clk(core_clk), .rst_b(rst_b),
    .host_select_n(pins.host_select_n), .host_data_strobe_one(pins.host_data_strobe_one),
    .host_data_strobe_two(pins.host_data_strobe_two), .half_word_select(pins.half_word_select),
    .address_latch_strobe_n(pins.address_latch_strobe_n), .host_ready_n(pins.host_ready_n),
    .access_type_select(pins.access_type_select), .read_write_select(pins.read_write_select),
    .host_data_oe_n_d(pins.host_data_oe_n_d), .host_data_oe_n_h(pins.host_data_oe_n_h));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic hps_pkg::hps_word_t fword(input int k);
    return 32'hA5C30000 + 32'(k) * 32'h00100001;
  endfunction
  // ----------------
  // fetch model, delay set per scenario
  // ----------------
  always @(negedge core_clk) begin
    fetch_ack <= 1'b0;
    if (fetch_req === 1'b1 && !fetch_ack) begin
      if (fcnt >= fdly) begin
        fetch_ack <= 1'b1;
        fetch_data <= fword(n_fetch);
        n_fetch <= n_fetch + 1;
        fcnt <= 0;
      end else fcnt <= fcnt + 1;
    end
  end
  always @(posedge core_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) drained.push_back(wr_data);
  end
  // ----------------
  // tasks
  // ----------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input hps_pkg::hps_word_t seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait at falling edges; a hang ends the run
  task automatic await_idle(input bit rsp);
    int k;
    for (k = 0; k < 400 && (rsp ? rsp_valid : cmd_ready) !== 1'b1; k++) @(negedge core_clk);
    if (k == 400) begin
      n_fail++;
      close_out;
    end
  endtask
  task automatic cmd(input logic rd, hf, input hps_pkg::hps_ctl_t c, input hps_pkg::hps_word_t w);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_half = hf;
    cmd_ctl = c;
    cmd_wdata = w;
    await_idle(1'b0);
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic rd(input logic hf, input hps_pkg::hps_word_t exp, mask);
    cmd(1'b1, hf, 2'h3, 32'h0);
    await_idle(1'b1);
    check("read word", rsp_data & mask, exp & mask);
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    {rst_b, narrow_bus_mode, cmd_valid, cmd_read, cmd_half, wr_ready} = 6'h0;
    cmd_ctl = 2'h0;
    cmd_wdata = 32'h0;
    fetch_data = 32'h0;
    {fdly, fcnt, n_fetch, n_fail, samples_checked} = {32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    exp_w = 32'h0;
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    rd(1'b0, fword(0), 32'hFFFFFFFF);
    fdly = 12;
    rd(1'b0, fword(1), 32'hFFFFFFFF);
    check("fetches", 32'(n_fetch), 32'h2);
    narrow_bus_mode = 1'b1;
    rd(1'b0, fword(2), 32'hFFFF);
    rd(1'b1, fword(2) >> 16, 32'hFFFF);
    // non-data read returns the held word and starts no fetch
    cmd(1'b1, 1'b0, 2'h1, 32'h0);
    await_idle(1'b1);
    check("register word", rsp_data, fword(2));
    check("fetches", 32'(n_fetch), 32'h3);
    narrow_bus_mode = 1'b0;
    // sink stalled: two words fit, the third must be held off
    for (i = 0; i < 3; i++) cmd(1'b0, 1'b0, 2'h3, 32'hC0DE0000 + 32'(i));
    repeat (20) @(negedge core_clk);
    check("ready while full", {31'h0, pins.host_ready_n}, 32'h1);
    check("host busy", {31'h0, cmd_ready}, 32'h0);
    wr_ready = 1'b1;
    await_idle(1'b0);
    // only the data codes reach memory
    for (i = 0; i < 4; i++) cmd(1'b0, 1'b0, 2'(i), 32'h5A000000 + 32'(i));
    await_idle(1'b0);
    repeat (4) @(negedge core_clk);
    check("words out", 32'(drained.size()), 32'h5);
    for (i = 0; i < 5 && i < drained.size(); i++) begin
      exp_w = (i < 3) ? 32'hC0DE0000 + 32'(i) : 32'h5A000000 + 32'(i - 1);
      check("word", drained[i], exp_w);
    end
    close_out;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    close_out;
  end
endmodule

//--- bench/hps_assertions.sv
// pin checker for the host port handshake
// assumes one core clock; the bench places it beside the interface
`timescale 1ns/1ps
module hps_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // pins
  input wire logic host_select_n,
  input wire logic host_data_strobe_one,
  input wire logic host_data_strobe_two,
  input wire logic address_latch_strobe_n,
  input wire hps_pkg::hps_ctl_t access_type_select,
  input wire logic read_write_select,
  input wire logic half_word_select,
  input wire logic host_ready_n,
  input wire logic host_data_oe_n_d,
  input wire logic host_data_oe_n_h
);
  logic stb;
  assign stb = ~(host_data_strobe_one ^ host_data_strobe_two) | host_select_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ----------------
  // properties
  // ----------------
  a_ready_in_strobe: assert property ($fell(host_ready_n) |-> !stb)
    else $error("ready fell outside a strobe");
  a_quals_steady: assert property (!stb && $past(!stb) |->
    $stable({access_type_select, read_write_select, half_word_select}))
    else $error("qualifiers moved in a strobe");
  a_hold_for_ready: assert property ($rose(stb) |-> $past(host_ready_n) == 1'b0)
    else $error("strobe released before ready");
  a_read_data_out: assert property (!host_ready_n && read_write_select && !stb
    |-> !host_data_oe_n_d)
    else $error("read ready without data driven");
  a_latch_once: assert property (!stb |-> !$fell(address_latch_strobe_n))
    else $error("second latch pulse in a strobe");
  a_low_min: assert property ($fell(stb) |-> !stb [*4])
    else $error("strobe low too short");
  a_high_min: assert property ($rose(stb) |-> stb [*4])
    else $error("strobe high gap too short");
  a_latch_first: assert property ($fell(stb) |-> !$past(address_latch_strobe_n))
    else $error("latch not ahead of strobe");
  a_half_quick: assert property ($fell(stb) && read_write_select && half_word_select
    |-> ##[1:5] !host_ready_n)
    else $error("second half late");
  a_bus_one_driver: assert property (host_data_oe_n_h || host_data_oe_n_d)
    else $error("both ends drive the data bus");
  c_read: cover property ($fell(stb) && read_write_select && !half_word_select);
  c_half: cover property ($fell(stb) && read_write_select && half_word_select);
  c_write: cover property ($fell(stb) && !read_write_select);
  c_write_wait: cover property (!stb && !read_write_select && host_ready_n [*8]);
endmodule

//--- design/hps_consts.svh
// timing counts and field encodings for the host port strobe handshake
// assumes a 125 MHz core clock shared by both ends
`ifndef HPS_CONSTS_SVH
`define HPS_CONSTS_SVH
`define HPS_CLK_PERIOD_PS 8000
`define HPS_STB_LOW_MIN_PS 12500
`define HPS_STB_P_PERIODS 4
// least low time: max(4P, 12.5 ns) rounded up to cycles
`define HPS_STB_LOW_CYC ((`HPS_STB_LOW_MIN_PS + `HPS_CLK_PERIOD_PS - 1) / `HPS_CLK_PERIOD_PS \
  > `HPS_STB_P_PERIODS ? (`HPS_STB_LOW_MIN_PS + `HPS_CLK_PERIOD_PS - 1) / `HPS_CLK_PERIOD_PS \
  : `HPS_STB_P_PERIODS)
`define HPS_STB_HIGH_CYC `HPS_STB_P_PERIODS
// second half-word deadline: 4P + 8 ns, rounded down
`define HPS_HW2_EXTRA_PS 8000
`define HPS_HW2_CYC (`HPS_STB_P_PERIODS + `HPS_HW2_EXTRA_PS / `HPS_CLK_PERIOD_PS)
`define HPS_CTL_DATA 2'h3
`define HPS_CTL_DATA_AUTO 2'h2
`endif

//--- design/hps_device.sv
// device end of the host port: forms the combined strobe, runs ready
// assumes the host keeps its handshake duties; memory side is valid/ready
`timescale 1ns/1ps
`include "hps_consts.svh"
module hps_device #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // pins
  hps_if.dev pins,
  // mode strap: high selects the narrow bus for data reads only
  input wire logic narrow_bus_mode,
  // fetch request to the internal dma address generator
  output logic fetch_req,
  input wire logic fetch_ack,
  input wire logic [WIDTH-1:0] fetch_data,
  // write words towards memory
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [WIDTH-1:0] wr_data
);
  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  localparam int SW = 8;
  logic [SW-1:0] raw, s1_q, s1_d, s2_q, s2_d;
  logic stb_raw;
  assign stb_raw = ~(pins.host_data_strobe_one ^ pins.host_data_strobe_two)
                   | pins.host_select_n;
  assign raw = {stb_raw, pins.access_type_select, pins.read_write_select,
                pins.half_word_select, pins.address_latch_strobe_n, 2'h0};
  always_comb begin
    s1_d = raw;
    s2_d = s1_q;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s1_q <= {1'b1, 7'h00};
      s2_q <= {1'b1, 7'h00};
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  logic stb_s, rw_s, hw_s;
  hps_pkg::hps_ctl_t ctl_s;
  assign stb_s = s2_q[7];
  assign ctl_s = s2_q[6:5];
  assign rw_s = s2_q[4];
  assign hw_s = s2_q[3];
  logic is_data;
  assign is_data = (ctl_s == `HPS_CTL_DATA) || (ctl_s == `HPS_CTL_DATA_AUTO);
  // ------------------------------------------------------------
  // write buffer: two-entry fifo in flip-flops
  // ------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [$clog2(DEPTH):0] cnt_q, cnt_d;
  logic [$clog2(DEPTH)-1:0] rp_q, rp_d, wp_q, wp_d;
  logic push, pop, full;
  logic [WIDTH-1:0] push_word;
  assign full = (cnt_q == ($clog2(DEPTH)+1)'(DEPTH));
  assign wr_valid = (cnt_q != '0);
  assign pop = wr_valid & wr_ready;
  assign wr_data = mem_q[rp_q];
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (push) begin
      mem_d[wp_q] = push_word;
    end
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + ($clog2(DEPTH)+1)'(push) - ($clog2(DEPTH)+1)'(pop);
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      cnt_q <= '0;
      rp_q <= '0;
      wp_q <= '0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rp_q <= rp_d;
      wp_q <= wp_d;
    end
  end
  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    HPS_IDLE = 5'h01,
    HPS_FETCH = 5'h02,
    HPS_RDY = 5'h04,
    HPS_WBUF = 5'h08,
    HPS_DONE = 5'h10
  } hps_st_e;
  hps_st_e st_q, st_d;
  logic stb_prev_q, stb_prev_d;
  logic [WIDTH-1:0] dreg_q, dreg_d;
  logic [WIDTH-1:0] hwhold_q, hwhold_d;
  logic rdy_n_q, rdy_n_d;
  logic oe_n_q, oe_n_d;
  logic [WIDTH-1:0] dout_q, dout_d;
  logic fall;
  assign fall = stb_prev_q & ~stb_s;
  always_comb begin
    st_d = st_q;
    stb_prev_d = stb_s;
    dreg_d = dreg_q;
    hwhold_d = hwhold_q;
    rdy_n_d = rdy_n_q;
    oe_n_d = oe_n_q;
    dout_d = dout_q;
    push = 1'b0;
    push_word = '0;
    fetch_req = 1'b0;
    case (st_q)
      HPS_IDLE: begin
        rdy_n_d = 1'b1;
        oe_n_d = 1'b1;
        if (fall) begin
          if (rw_s && is_data && (!narrow_bus_mode || !hw_s)) begin
            st_d = HPS_FETCH;
          end else if (rw_s && is_data) begin
            // second half: drive held upper half at once, no fetch
            dout_d = hwhold_q;
            oe_n_d = 1'b0;
            st_d = HPS_RDY;
          end else if (rw_s) begin
            dout_d = dreg_q;
            oe_n_d = 1'b0;
            st_d = HPS_RDY;
          end else begin
            st_d = HPS_WBUF;
          end
        end
      end
      HPS_FETCH: begin
        fetch_req = 1'b1;
        if (fetch_ack) begin
          dreg_d = fetch_data;
          hwhold_d = {{(WIDTH/2){1'b0}}, fetch_data[WIDTH-1:WIDTH/2]};
          dout_d = narrow_bus_mode ? {{(WIDTH/2){1'b0}}, fetch_data[WIDTH/2-1:0]}
                                   : fetch_data;
          oe_n_d = 1'b0;
          st_d = HPS_RDY; // ready waits for the load
        end
      end
      HPS_RDY: begin
        rdy_n_d = 1'b0;
        if (stb_s) begin
          st_d = HPS_IDLE;
        end
      end
      HPS_WBUF: begin
        // host data sampled while strobe low; stable before rising edge
        if (!full) begin
          rdy_n_d = 1'b0;
          push = is_data;
          push_word = pins.host_data_bus_h;
          st_d = HPS_DONE;
        end else begin
          rdy_n_d = 1'b1;
        end
      end
      HPS_DONE: begin
        if (stb_s) begin
          st_d = HPS_IDLE;
        end
      end
      default: st_d = HPS_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= HPS_IDLE;
      stb_prev_q <= 1'b1;
      dreg_q <= '0;
      hwhold_q <= '0;
      rdy_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dout_q <= '0;
    end else begin
      st_q <= st_d;
      stb_prev_q <= stb_prev_d;
      dreg_q <= dreg_d;
      hwhold_q <= hwhold_d;
      rdy_n_q <= rdy_n_d;
      oe_n_q <= oe_n_d;
      dout_q <= dout_d;
    end
  end
  assign pins.host_ready_n = rdy_n_q;
  assign pins.host_data_bus_d = dout_q;
  assign pins.host_data_oe_n_d = oe_n_q;
endmodule

//--- design/hps_host.sv
// host end: issues one access per command, honouring strobe timing
// assumes the device answers ready within the wait it needs
`timescale 1ns/1ps
`include "hps_consts.svh"
module hps_host #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // pins
  hps_if.host pins,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_half,
  input wire hps_pkg::hps_ctl_t cmd_ctl,
  input wire logic [WIDTH-1:0] cmd_wdata,
  // read answer
  output logic rsp_valid,
  output logic [WIDTH-1:0] rsp_data
);
  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    HH_IDLE = 4'h1,
    HH_ALE = 4'h2,
    HH_LOW = 4'h4,
    HH_HIGH = 4'h8
  } hh_st_e;
  localparam logic [3:0] LOWC = 4'(`HPS_STB_LOW_CYC);
  localparam logic [3:0] HIGHC = 4'(`HPS_STB_HIGH_CYC);
  hh_st_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic rd_q, rd_d, hw_q, hw_d, ale_q, ale_d, strobe_q, strobe_d, rv_q, rv_d;
  hps_pkg::hps_ctl_t ctl_q, ctl_d;
  logic [WIDTH-1:0] wd_q, wd_d, rsp_q, rsp_d;
  assign cmd_ready = (st_q == HH_IDLE);
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    hw_d = hw_q;
    ctl_d = ctl_q;
    wd_d = wd_q;
    ale_d = 1'b1;
    strobe_d = strobe_q;
    rsp_d = rsp_q;
    rv_d = 1'b0;
    case (st_q)
      HH_IDLE: begin
        if (cmd_valid) begin
          rd_d = cmd_read;
          hw_d = cmd_half;
          ctl_d = cmd_ctl;
          wd_d = cmd_wdata;
          ale_d = 1'b0; // latch strobe leads the data strobe
          st_d = HH_ALE;
        end
      end
      HH_ALE: begin
        strobe_d = 1'b0; // single latch pulse per access
        cnt_d = '0;
        st_d = HH_LOW;
      end
      HH_LOW: begin
        if (cnt_q != LOWC) begin
          cnt_d = cnt_q + 4'h1;
        end
        if (cnt_q == LOWC && !pins.host_ready_n) begin
          strobe_d = 1'b1;
          rsp_d = pins.host_data_bus_d;
          rv_d = rd_q;
          cnt_d = '0;
          st_d = HH_HIGH;
        end
      end
      HH_HIGH: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == HIGHC - 4'h1) begin
          st_d = HH_IDLE;
        end
      end
      default: st_d = HH_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= HH_IDLE;
      cnt_q <= '0;
      rd_q <= 1'b1;
      hw_q <= 1'b0;
      ctl_q <= '0;
      wd_q <= '0;
      ale_q <= 1'b1;
      strobe_q <= 1'b1;
      rsp_q <= '0;
      rv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      hw_q <= hw_d;
      ctl_q <= ctl_d;
      wd_q <= wd_d;
      ale_q <= ale_d;
      strobe_q <= strobe_d;
      rsp_q <= rsp_d;
      rv_q <= rv_d;
    end
  end
  // reads strobe on data strobe one, writes on two; select tied active
  // both strobes rest low, so the combined strobe idles inactive
  assign pins.host_select_n = 1'b0;
  assign pins.host_data_strobe_one = rd_q & ~strobe_q;
  assign pins.host_data_strobe_two = ~rd_q & ~strobe_q;
  assign pins.address_latch_strobe_n = ale_q;
  assign pins.access_type_select = ctl_q;
  assign pins.read_write_select = rd_q;
  assign pins.half_word_select = hw_q;
  assign pins.host_data_bus_h = wd_q;
  assign pins.host_data_oe_n_h = rd_q;
  assign rsp_valid = rv_q;
  assign rsp_data = rsp_q;
endmodule

//--- design/hps_if.sv
// pin bundle between the host controller and the device host port
// the data bus is split into value and enable; each end reads the other end's value directly
`timescale 1ns/1ps
interface hps_if;
  logic host_select_n;
  logic host_data_strobe_one;
  logic host_data_strobe_two;
  logic address_latch_strobe_n;
  hps_pkg::hps_ctl_t access_type_select;
  logic read_write_select;
  logic half_word_select;
  logic host_ready_n;
  hps_pkg::hps_word_t host_data_bus_h;
  logic host_data_oe_n_h;
  hps_pkg::hps_word_t host_data_bus_d;
  logic host_data_oe_n_d;
  modport dev (
    input host_select_n, host_data_strobe_one, host_data_strobe_two,
    input address_latch_strobe_n, access_type_select, read_write_select,
    input half_word_select, host_data_bus_h, host_data_oe_n_h,
    output host_ready_n, host_data_bus_d, host_data_oe_n_d
  );
  modport host (
    output host_select_n, host_data_strobe_one, host_data_strobe_two,
    output address_latch_strobe_n, access_type_select, read_write_select,
    output half_word_select, host_data_bus_h, host_data_oe_n_h,
    input host_ready_n, host_data_bus_d, host_data_oe_n_d
  );
endinterface

//--- design/hps_pkg.sv
// types shared by both ends of the host port handshake
// no assumptions beyond the consts header
package hps_pkg;
  typedef logic [1:0] hps_ctl_t;
  typedef logic [31:0] hps_word_t;
endpackage
